/* File: hw/mic_consts.svh */
// Register offsets, field positions and reset values of the control block
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH

`define MIC_ADDR_W 12
`define MIC_CTRL_ADDR 12'h000
`define MIC_STAT_ADDR 12'h004

`define MIC_CTRL_W 3
`define MIC_CTRL_NOP_SLEEP 0
`define MIC_CTRL_BRK_LOCK 1
`define MIC_CTRL_PEND_WAKE 2
`define MIC_CTRL_RST 3'h0

`define MIC_STAT_EVENT 0
`define MIC_STAT_SLEEP 1
`define MIC_STAT_MASK 2
`define MIC_STAT_LOCK 3
`define MIC_STAT_FLAGS 4

`define MIC_FLAG_MSB 31
`define MIC_FLAG_LSB 28
`define MIC_T_BIT 24
`define MIC_CONTROL_W 2

`endif

/* File: hw/mic_pkg.sv */
// Types shared by the miscellaneous-instruction control block
package mic_pkg;

    typedef enum logic [3:0] {
        OP_NO_OPERATION,
        OP_BREAKPOINT,
        OP_MASK_SET,
        OP_MASK_CLR,
        OP_MEM_BAR,
        OP_SYNC_BAR,
        OP_INSTR_BAR,
        OP_SREG_RD,
        OP_SREG_WR,
        OP_SEND_EVENT,
        OP_SUPV_CALL,
        OP_WAIT_EVENT,
        OP_WAIT_IRQ
    } mic_op_e;

    typedef enum logic [3:0] {
        SR_APP_STATUS,
        SR_INT_STATUS,
        SR_EXEC_STATUS,
        SR_INT_EXEC,
        SR_INT_APP,
        SR_EXEC_APP,
        SR_COMBINED,
        SR_MAIN_SP,
        SR_PROC_SP,
        SR_INT_MASK,
        SR_CONTROL
    } mic_sreg_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SYNC_WAIT,
        ST_SLEEP_EVENT,
        ST_SLEEP_IRQ
    } mic_state_e;

    typedef struct packed {
        mic_op_e op;
        mic_sreg_e sreg;
        logic [31:0] rn_val;
        logic [7:0] imm;
    } mic_instr_s;

    typedef struct packed {
        logic exc_unmasked;
        logic exc_any;
        logic pend_new;
        logic irq_preempt;
        logic dbg_req;
        logic ext_event;
    } mic_wake_s;

endpackage

/* File: hw/mic_event_reg.sv */
// Local event register: one sticky bit, set wins over clear
`timescale 1ns/1ps
module mic_event_reg (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic set_ev,
    input wire logic clr_ev,
    output logic event_q
);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            event_q <= 1'b0;
        end else if (set_ev) begin
            event_q <= 1'b1;
        end else if (clr_ev) begin
            event_q <= 1'b0;
        end
    end

endmodule

/* File: hw/mic_ctrl.sv */
// Execution control of miscellaneous instructions with APB control regs
//
// How it works
// - Breakpoint enters debug state; its 8-bit immediate is ignored.
// - Without debugger, breakpoint raises hard fault or locks up.
// - Mask-set form sets the interrupt mask bit; mask-clear clears it.
// - Unprivileged change-state acts as no-operation; mask unchanged.
// - Data memory barrier orders memory accesses only, not other work.
// - Sync barrier stalls later instructions until earlier accesses end.
// - Instruction barrier flushes the pipeline for refetch.
// - Special register read copies chosen register to a general one.
// - Unprivileged special reads other than application status give 0.
// - Special register write loads chosen register from source.
// - Unprivileged special writes except application status ignored.
// - Special write to a flag-holding view sets flags from source.
// - No other instruction here changes the condition flags.
// - No-operation has no effect and completes at once.
// - Send-event signals all processors and sets local event bit.
// - Supervisor call raises its exception; immediate is ignored.
// - Supervisor call at equal or higher priority faults instead.
// - Wait-for-event with event bit 0 sleeps until a wake condition.
// - Wait-for-event wakes on exception, pend, debug or event.
// - Wait-for-event with event bit 1 clears it and completes.
// - Wait-for-interrupt wakes on exception, preempting pend, debug.
// - Both sleep instructions may run as no-operation.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "mic_consts.svh"
module mic_ctrl (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire mic_pkg::mic_instr_s instr,
    output logic instr_ready,
    output logic instr_done,
    input wire logic privileged,
    input wire logic [5:0] interrupt_status_reg_num,
    input wire logic thumb_bit,
    input wire logic [7:0] exec_prio,
    input wire logic [7:0] svc_prio,
    input wire logic mem_pending,
    input wire logic dbg_attached,
    input wire logic dbg_enabled,
    input wire mic_pkg::mic_wake_s wake,
    output logic debug_entry,
    output logic hard_fault,
    output logic lockup,
    output logic svc_exc,
    output logic pipe_flush,
    output logic mem_hold,
    output logic sev_out,
    output logic sleeping,
    output logic rd_we,
    output logic [31:0] rd_data,
    output logic [3:0] cond_flags,
    output logic int_mask,
    output logic [1:0] control_val,
    output logic [31:0] main_sp,
    output logic [31:0] proc_sp
);
    import mic_pkg::*;

    mic_state_e state_q, state_d;
    logic ready_q, done_q, take, done_d;
    logic [`MIC_CTRL_W-1:0] ctrl_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [3:0] flags_q;
    logic interrupt_mask_reg_q;
    logic [1:0] control_q;
    logic [31:0] msp_q, psp_q;
    logic rd_we_q;
    logic [31:0] rd_data_q;
    logic dbg_q, hf_q, lock_q, svc_q, flush_q, hold_q, sev_q, sleep_q;
    logic event_q, nop_sleep, wfe_wake, wfi_wake, ev_set, ev_clr;
    logic setup, wr_acc;

    assign take = instr_valid & ready_q;
    assign nop_sleep = ctrl_q[`MIC_CTRL_NOP_SLEEP];

    assign wfe_wake = event_q | wake.exc_unmasked
        | (wake.pend_new & ctrl_q[`MIC_CTRL_PEND_WAKE])
        | (wake.dbg_req & dbg_enabled);
    // wake causes for wait-for-interrupt, debug always counts
    assign wfi_wake = wake.exc_any | wake.irq_preempt | wake.dbg_req;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    case (instr.op)
                        OP_SYNC_BAR: begin
                            if (mem_pending) begin
                                state_d = ST_SYNC_WAIT;
                            end
                        end
                        // sleep only when no event is held
                        OP_WAIT_EVENT: begin
                            if (!nop_sleep && !event_q) begin
                                state_d = ST_SLEEP_EVENT;
                            end
                        end
                        // sleep may be turned into no-operation
                        OP_WAIT_IRQ: begin
                            if (!nop_sleep) begin
                                state_d = ST_SLEEP_IRQ;
                            end
                        end
                        default: state_d = ST_IDLE;
                    endcase
                end
            end
            ST_SYNC_WAIT: begin
                if (!mem_pending) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SLEEP_EVENT: begin
                if (wfe_wake) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SLEEP_IRQ: begin
                if (wfi_wake) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // one-cycle ops, no-operation included, finish next cycle
    assign done_d = (state_d == ST_IDLE)
        && (take || state_q != ST_IDLE);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b0;
            done_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == ST_IDLE);
            done_q <= done_d;
            sleep_q <= (state_d == ST_SLEEP_EVENT)
                || (state_d == ST_SLEEP_IRQ);
        end
    end

    // own send-event sets the local bit; outside events too
    assign ev_set = (take && instr.op == OP_SEND_EVENT) | wake.ext_event;
    // held event is consumed by wait-for-event
    assign ev_clr = (take && instr.op == OP_WAIT_EVENT && !nop_sleep)
        || (state_q == ST_SLEEP_EVENT && state_d == ST_IDLE);

    mic_event_reg u_event (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .set_ev(ev_set),
        .clr_ev(ev_clr),
        .event_q(event_q)
    );

    function automatic logic has_flags(mic_sreg_e s);
        return s == SR_APP_STATUS || s == SR_INT_APP
            || s == SR_EXEC_APP || s == SR_COMBINED;
    endfunction

    function automatic logic [31:0] sreg_val(mic_sreg_e s);
        logic [31:0] app;
        logic [31:0] ist;
        logic [31:0] est;
        app = {flags_q, 28'h0000000};
        ist = {26'h0, interrupt_status_reg_num};
        est = 32'h00000000;
        est[`MIC_T_BIT] = thumb_bit;
        case (s)
            SR_APP_STATUS: sreg_val = app;
            SR_INT_STATUS: sreg_val = ist;
            SR_EXEC_STATUS: sreg_val = est;
            SR_INT_EXEC: sreg_val = ist | est;
            SR_INT_APP: sreg_val = app | ist;
            SR_EXEC_APP: sreg_val = app | est;
            SR_COMBINED: sreg_val = app | ist | est;
            SR_MAIN_SP: sreg_val = msp_q;
            SR_PROC_SP: sreg_val = psp_q;
            SR_INT_MASK: sreg_val = {31'h0, interrupt_mask_reg_q};
            SR_CONTROL: sreg_val = {30'h0, control_q};
            default: sreg_val = 32'h00000000;
        endcase
    endfunction

    // Special registers; only the write op may touch the flags
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            flags_q <= 4'h0;
            interrupt_mask_reg_q <= 1'b0;
            control_q <= 2'h0;
            msp_q <= 32'h00000000;
            psp_q <= 32'h00000000;
        end else if (take) begin
            case (instr.op)
                OP_MASK_SET: if (privileged) interrupt_mask_reg_q <= 1'b1;
                OP_MASK_CLR: if (privileged) interrupt_mask_reg_q <= 1'b0;
                OP_SREG_WR: begin
                    // flags taken straight from source bits
                    // no other op reaches the flags
                    if (has_flags(instr.sreg) && (privileged
                        || instr.sreg == SR_APP_STATUS)) begin
                        flags_q <= instr.rn_val[`MIC_FLAG_MSB:
                            `MIC_FLAG_LSB];
                    end
                    if (privileged) begin
                        case (instr.sreg)
                            SR_MAIN_SP: msp_q <= instr.rn_val;
                            SR_PROC_SP: psp_q <= instr.rn_val;
                            SR_INT_MASK: interrupt_mask_reg_q <= instr.rn_val[0];
                            SR_CONTROL: control_q <= instr.rn_val[1:0];
                            default: control_q <= control_q;
                        endcase
                    end
                end
                default: flags_q <= flags_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rd_we_q <= 1'b0;
            rd_data_q <= 32'h00000000;
        end else begin
            rd_we_q <= take && instr.op == OP_SREG_RD;
            if (take && instr.op == OP_SREG_RD) begin
                rd_data_q <= (privileged || instr.sreg == SR_APP_STATUS)
                    ? sreg_val(instr.sreg) : 32'h00000000;
            end
        end
    end

    // Exception requests; lockup stays until reset by design
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            dbg_q <= 1'b0;
            hf_q <= 1'b0;
            svc_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            dbg_q <= 1'b0;
            hf_q <= 1'b0;
            svc_q <= 1'b0;
            if (take && instr.op == OP_BREAKPOINT) begin
                // debug entry when a debugger listens
                // otherwise fault or lockup as configured
                if (dbg_attached) begin
                    dbg_q <= 1'b1;
                end else if (ctrl_q[`MIC_CTRL_BRK_LOCK]) begin
                    lock_q <= 1'b1;
                end else begin
                    hf_q <= 1'b1;
                end
            end
            if (take && instr.op == OP_SUPV_CALL) begin
                if (exec_prio <= svc_prio) begin
                    hf_q <= 1'b1;
                end else begin
                    svc_q <= 1'b1;
                end
            end
        end
    end

    // Barriers and event broadcast
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            flush_q <= 1'b0;
            hold_q <= 1'b0;
            sev_q <= 1'b0;
        end else begin
            flush_q <= take && instr.op == OP_INSTR_BAR;
            // hold later memory ops only; the barrier retires
            hold_q <= ((take && instr.op == OP_MEM_BAR) || hold_q)
                && mem_pending;
            sev_q <= take && instr.op == OP_SEND_EVENT;
        end
    end

    // APB slave, answers in the first access cycle
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready_q & pwrite;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_q <= `MIC_CTRL_RST;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && paddr != `MIC_CTRL_ADDR
                && paddr != `MIC_STAT_ADDR;
            if (setup) begin
                prdata_q <= 32'h00000000;
                if (!pwrite && paddr == `MIC_CTRL_ADDR) begin
                    prdata_q[`MIC_CTRL_W-1:0] <= ctrl_q;
                end
                if (!pwrite && paddr == `MIC_STAT_ADDR) begin
                    prdata_q[`MIC_STAT_EVENT] <= event_q;
                    prdata_q[`MIC_STAT_SLEEP] <= sleep_q;
                    prdata_q[`MIC_STAT_MASK] <= interrupt_mask_reg_q;
                    prdata_q[`MIC_STAT_LOCK] <= lock_q;
                    prdata_q[`MIC_STAT_FLAGS+3:`MIC_STAT_FLAGS] <= flags_q;
                end
            end
            if (wr_acc && paddr == `MIC_CTRL_ADDR) begin
                ctrl_q <= pwdata[`MIC_CTRL_W-1:0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign instr_ready = ready_q;
    assign instr_done = done_q;
    assign debug_entry = dbg_q;
    assign hard_fault = hf_q;
    assign lockup = lock_q;
    assign svc_exc = svc_q;
    assign pipe_flush = flush_q;
    assign mem_hold = hold_q;
    assign sev_out = sev_q;
    assign sleeping = sleep_q;
    assign rd_we = rd_we_q;
    assign rd_data = rd_data_q;
    assign cond_flags = flags_q;
    assign int_mask = interrupt_mask_reg_q;
    assign control_val = control_q;
    assign main_sp = msp_q;
    assign proc_sp = psp_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_take(mic_op_e o);
        take && instr.op == o;
    endsequence

    sequence s_wfe_park;
        s_take(OP_WAIT_EVENT) ##0 (!event_q && !nop_sleep);
    endsequence

    a_breakpoint_instr_debug_entry: assert property (
        s_take(OP_BREAKPOINT) ##0 dbg_attached |=> dbg_q && !hf_q)
        else $error("breakpoint missed debug entry");

    a_breakpoint_instr_no_debugger: assert property (
        s_take(OP_BREAKPOINT) ##0 !dbg_attached |=> (hf_q || lock_q) && !dbg_q)
        else $error("breakpoint without debugger not faulted");

    a_mask_set_priv: assert property (
        s_take(OP_MASK_SET) ##0 privileged |=> interrupt_mask_reg_q && done_q)
        else $error("mask set failed");

    a_mask_unpriv_hold: assert property (
        (take && !privileged && (instr.op == OP_MASK_SET
        || instr.op == OP_MASK_CLR)) |=> $stable(interrupt_mask_reg_q))
        else $error("unprivileged mask change");

    a_mem_bar_hold: assert property (
        s_take(OP_MEM_BAR) ##0 mem_pending |=> hold_q && done_q)
        else $error("memory barrier did not hold accesses");

    a_sync_bar_wait: assert property (
        s_take(OP_SYNC_BAR) ##0 mem_pending ##1 mem_pending
        |=> !done_q && !ready_q)
        else $error("sync barrier completed early");

    a_instr_bar_flush: assert property (
        s_take(OP_INSTR_BAR) |=> flush_q && done_q ##1 !flush_q)
        else $error("instruction barrier flush missing");

    a_read_unpriv_zero: assert property (
        s_take(OP_SREG_RD) ##0 (!privileged && instr.sreg != SR_APP_STATUS)
        |=> rd_we_q && rd_data_q == 32'h00000000)
        else $error("unprivileged read not zero");

    a_write_unpriv_drop: assert property (
        s_take(OP_SREG_WR) ##0 !privileged |=> $stable(msp_q)
        && $stable(psp_q) && $stable(interrupt_mask_reg_q) && $stable(control_q))
        else $error("unprivileged special write took effect");

    a_write_flags_set: assert property (
        s_take(OP_SREG_WR) ##0 instr.sreg == SR_APP_STATUS
        |=> flags_q == $past(instr.rn_val[31:28]))
        else $error("flags not loaded from source");

    a_flags_stable: assert property (
        !(take && instr.op == OP_SREG_WR) |=> $stable(flags_q))
        else $error("flags changed by other op");

    a_send_event_out: assert property (
        s_take(OP_SEND_EVENT) |=> sev_q && event_q)
        else $error("send event not signalled");

    a_svc_fault_route: assert property (
        s_take(OP_SUPV_CALL) ##0 exec_prio <= svc_prio |=> hf_q && !svc_q)
        else $error("supervisor call at high priority not faulted");

    a_wfe_sleep_enter: assert property (
        s_wfe_park ##1 !wfe_wake |=> sleep_q && !done_q)
        else $error("wait for event did not sleep");

    a_wfe_event_clear: assert property (
        s_take(OP_WAIT_EVENT) ##0 (event_q && !nop_sleep && !wake.ext_event)
        |=> done_q && !event_q && !sleep_q)
        else $error("held event not consumed");

    a_wfi_debug_wake: assert property (
        state_q == ST_SLEEP_IRQ && wake.dbg_req |=> done_q && !sleep_q)
        else $error("debug request did not wake");

endmodule

/* File: tb/mic_far_model.sv */
// Far-side model: wake sources and outstanding memory traffic
`timescale 1ns/1ps
module mic_far_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic sleeping,
    input wire logic [5:0] arm_bits,
    input wire logic [3:0] arm_dly,
    input wire logic mem_go,
    output mic_pkg::mic_wake_s wake,
    output logic mem_pending
);
    import mic_pkg::*;
    logic [3:0] cnt_q;
    logic [3:0] mcnt_q;

    // One-cycle wake only: the core must catch it, not wait for a level
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !sleeping) begin
            cnt_q <= 4'h0;
            wake <= '0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            wake <= (cnt_q == arm_dly) ? mic_wake_s'(arm_bits) : '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mcnt_q <= 4'h0;
        end else if (mem_go) begin
            mcnt_q <= arm_dly;
        end else if (mcnt_q != 4'h0) begin
            mcnt_q <= mcnt_q - 4'h1;
        end
    end
    assign mem_pending = (mcnt_q != 4'h0);
endmodule

/* File: tb/misc_instruction_control_tb.sv */
// Self-checking bench for the miscellaneous-instruction control block
`timescale 1ns/1ps
`include "mic_consts.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
 $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module misc_instruction_control_tb;
    import mic_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic instr_valid = 1'b0;
    mic_instr_s instr = '0;
    logic priv = 1'b1;
    logic [7:0] eprio = 8'hff;
    logic dbg_att = 1'b0;
    logic dbg_en = 1'b0;
    logic [5:0] arm_bits = 6'h00;
    logic [3:0] arm_dly = 4'h4;
    logic mem_go = 1'b0;
    mic_wake_s wake;
    logic mem_pending, pready, pslverr, instr_ready, instr_done;
    logic debug_entry, hard_fault, lockup, svc_exc, pipe_flush;
    logic mem_hold, sev_out, sleeping, rd_we, int_mask;
    logic [31:0] prdata, rd_data, main_sp, rdata;
    logic [3:0] cond_flags;
    logic [5:0] side;
    logic rerr;
    int n;
    int err_total = 0;
    int tests_run = 0;

    mic_ctrl dut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr,
        .instr_ready, .instr_done, .privileged(priv), .interrupt_status_reg_num(6'h05),
        .thumb_bit(1'b1), .exec_prio(eprio), .svc_prio(8'h40),
        .mem_pending, .dbg_attached(dbg_att), .dbg_enabled(dbg_en), .wake,
        .debug_entry, .hard_fault, .lockup, .svc_exc, .pipe_flush,
        .mem_hold, .sev_out, .sleeping, .rd_we, .rd_data, .cond_flags,
        .int_mask, .control_val(), .main_sp, .proc_sp());
    mic_far_model far (.sys_clk, .reset_n, .sleeping, .arm_bits, .arm_dly,
        .mem_go, .wake, .mem_pending);

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic exec(input mic_op_e op, input mic_sreg_e sr,
                        input logic [31:0] v);
        instr_valid <= 1'b1;
        instr <= '{op, sr, v, 8'hff};
        n = 0;
        do @(posedge sys_clk); while (instr_ready !== 1'b1 && ++n < 50);
        // Scramble the request once taken so stale values are not reused
        instr_valid <= 1'b0;
        instr <= '{OP_NO_OPERATION, SR_CONTROL, ~v, 8'h00};
        n = 0;
        do @(posedge sys_clk); while (instr_done !== 1'b1 && ++n < 200);
        side = {debug_entry, hard_fault, svc_exc, pipe_flush, sev_out, rd_we};
    endtask

    task automatic t_regs();
        apb(1'b0, `MIC_STAT_ADDR, 32'h0);
        `CHK(rdata, 32'h0)
        apb(1'b1, `MIC_CTRL_ADDR, 32'h5);
        apb(1'b0, `MIC_CTRL_ADDR, 32'h0);
        `CHK(rdata[2:0], 3'h5)
        apb(1'b0, 12'h008, 32'h0);
        `CHK({rerr, rdata}, 33'h100000000)
        // Sleep ops real, pend wakes event wait, breakpoint faults
        apb(1'b1, `MIC_CTRL_ADDR, 32'h4);
        $display("test regs done");
    endtask

    task automatic t_mask();
        exec(OP_MASK_SET, SR_CONTROL, 32'h0);
        `CHK(int_mask, 1'b1)
        priv <= 1'b0;
        exec(OP_MASK_CLR, SR_CONTROL, 32'h0);
        `CHK(int_mask, 1'b1)
        priv <= 1'b1;
        exec(OP_MASK_CLR, SR_CONTROL, 32'h0);
        `CHK(int_mask, 1'b0)
        $display("test mask done");
    endtask

    task automatic t_sreg();
        exec(OP_SREG_WR, SR_APP_STATUS, 32'ha000_0000);
        `CHK(cond_flags, 4'ha)
        exec(OP_SREG_WR, SR_MAIN_SP, 32'h0000_1230);
        `CHK(main_sp, 32'h0000_1230)
        priv <= 1'b0;
        exec(OP_SREG_WR, SR_MAIN_SP, 32'h0000_4560);
        `CHK(main_sp, 32'h0000_1230)
        exec(OP_SREG_WR, SR_APP_STATUS, 32'h5000_0000);
        `CHK(cond_flags, 4'h5)
        exec(OP_SREG_RD, SR_MAIN_SP, 32'h0);
        `CHK({side, rd_data}, {6'h01, 32'h0})
        exec(OP_SREG_RD, SR_APP_STATUS, 32'h0);
        `CHK(rd_data, 32'h5000_0000)
        priv <= 1'b1;
        exec(OP_SREG_RD, SR_MAIN_SP, 32'h0);
        `CHK(rd_data, 32'h0000_1230)
        $display("test special regs done");
    endtask

    task automatic t_exc();
        dbg_att <= 1'b1;
        exec(OP_BREAKPOINT, SR_CONTROL, 32'h0);
        `CHK(side, 6'h20)
        dbg_att <= 1'b0;
        exec(OP_BREAKPOINT, SR_CONTROL, 32'h0);
        `CHK(side, 6'h10)
        eprio <= 8'h80;
        exec(OP_SUPV_CALL, SR_CONTROL, 32'h0);
        `CHK(side, 6'h08)
        eprio <= 8'h40;
        exec(OP_SUPV_CALL, SR_CONTROL, 32'h0);
        `CHK(side, 6'h10)
        $display("test exceptions done");
    endtask

    task automatic t_event();
        exec(OP_SEND_EVENT, SR_CONTROL, 32'h0);
        `CHK(side, 6'h02)
        exec(OP_WAIT_EVENT, SR_CONTROL, 32'h0);
        `CHK(n, 0)
        apb(1'b0, `MIC_STAT_ADDR, 32'h0);
        `CHK(rdata[1:0], 2'h0)
        exec(OP_NO_OPERATION, SR_CONTROL, 32'h0);
        `CHK(side, 6'h00)
        $display("test event done");
    endtask

    task automatic t_sleep();
        logic [5:0] src [7] = '{6'h20, 6'h08, 6'h02, 6'h01,
                                6'h10, 6'h04, 6'h02};
        for (int i = 0; i < 7; i++) begin
            arm_bits <= src[i];
            dbg_en <= (i == 2);
            if (i < 4) begin
                exec(OP_WAIT_EVENT, SR_CONTROL, 32'h0);
            end else begin
                exec(OP_WAIT_IRQ, SR_CONTROL, 32'h0);
            end
            `CHK(n, (i == 3) ? 7 : 6)
        end
        apb(1'b1, `MIC_CTRL_ADDR, 32'h1);
        exec(OP_WAIT_IRQ, SR_CONTROL, 32'h0);
        `CHK(n, 0)
        $display("test sleep done");
    endtask

    task automatic t_bar();
        mem_go <= 1'b1;
        arm_dly <= 4'h6;
        @(posedge sys_clk);
        mem_go <= 1'b0;
        exec(OP_MEM_BAR, SR_CONTROL, 32'h0);
        `CHK({n == 0, mem_hold}, 2'h3)
        repeat (8) @(posedge sys_clk);
        `CHK(mem_hold, 1'b0)
        mem_go <= 1'b1;
        @(posedge sys_clk);
        mem_go <= 1'b0;
        exec(OP_SYNC_BAR, SR_CONTROL, 32'h0);
        `CHK(n > 4, 1'b1)
        exec(OP_INSTR_BAR, SR_CONTROL, 32'h0);
        `CHK(side, 6'h04)
        `CHK(cond_flags, 4'h5)
        $display("test barriers done");
    endtask

    task automatic t_lock();
        exec(OP_SEND_EVENT, SR_CONTROL, 32'h0);
        apb(1'b1, `MIC_CTRL_ADDR, 32'h2);
        exec(OP_BREAKPOINT, SR_CONTROL, 32'h0);
        @(posedge sys_clk);
        `CHK(lockup, 1'b1)
        do_reset();
        apb(1'b0, `MIC_STAT_ADDR, 32'h0);
        `CHK({lockup, rdata}, 33'h0)
        $display("test lockup done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        results();
    end

    initial begin
        do_reset();
        t_regs();
        t_mask();
        t_sreg();
        t_exc();
        t_event();
        t_sleep();
        t_bar();
        t_lock();
        results();
    end
endmodule
